// *** logic/adc_seq_defines.vh ***
/*
  register offsets, field positions and reset values of the
  converter sequence controller. assumes byte-wide register port.
*/
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH

// register offsets
`define OFS_LENGTH_FIFO    8'h63
`define OFS_CLOCK_RES      8'h64
`define OFS_SEQ_CTRL       8'h65
`define OFS_STATUS_SEQ     8'h66
`define OFS_STATUS_CONV    8'h67
`define OFS_RESULT_BASE    8'h70
`define OFS_RESULT_LAST    8'h7f

// reset values
`define RST_LENGTH_FIFO    8'h00
`define RST_CLOCK_RES      8'h01
`define RST_SEQ_CTRL       8'h00

// length_fifo_reg fields
`define BIT_SINGLE_CONV    3
`define BIT_FIFO_MODE      2
`define MSK_LENGTH_FIFO    8'h0f

// clock_resolution_reg fields
`define BIT_RES10          7
`define PRS_MSB            4
`define PRS_USED_MSB       2

// sequence_control_reg fields
`define BIT_EIGHT_CONV     6
`define BIT_SCAN           5
`define BIT_MULTI          4
`define BIT_SPECIAL        3
`define CHAN_MSB           2
`define MSK_SEQ_CTRL       8'h7f

// status field
`define BIT_SEQ_DONE       7

// sequence lengths less one
`define LEN_ONE            3'h0
`define LEN_FOUR           3'h3
`define LEN_EIGHT          3'h7

`endif

// *** logic/adc_sequence_control.v ***
/*
  sequence controller of an 8-channel successive-approximation
  converter: control register decode, conversion clock prescaler,
  channel stepping, result register file and completion flags.
  assumes the conversion machine runs on REF_CLK, takes one start
  pulse per conversion and answers with a one-cycle done pulse.
*/
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`include "adc_seq_defines.vh"
`default_nettype none

// Function
// - prescale codes 0..7 divide by 2..16
// - control write aborts running sequence at once
// - control writes restart sequence, clear flags
// - eight bit wins, else single or four
// - normal mapping: result n to register n
// - fifo mapping continues across sequences, wraps
// - no scan: one sequence, flag, then idle
// - scan: flag then restart identical sequence
// - single channel mode repeats selected channel
// - multi channel mode increments channel code
// - channel code wraps from 7 to 0
// - special bit selects internal reference sources
// - special codes: high, low, midpoint references
// - channel code maps straight to input
// - modulus counter prs+1, then divide two
// - pointer zeroed around non-fifo sequences only
// - completion flag index equals result register
module adc_sequence_control #(
  parameter RES_W = 10
) (
  // clock and reset
  input  wire             REF_CLK,
  input  wire             RST_B,
  // register port
  input  wire [7:0]       ADDR,
  input  wire [7:0]       WDATA,
  input  wire             WR_STB,
  input  wire             RD_STB,
  output reg  [7:0]       RDATA,
  // conversion machine
  output wire             CONV_CLK_TICK,
  output wire             CONV_START,
  output wire             CONV_ABORT,
  output reg  [2:0]       CONV_CHANNEL,
  output reg              CONV_SPECIAL,
  output wire             CONV_RES10,
  input  wire             CONV_DONE,
  input  wire [RES_W-1:0] CONV_RESULT,
  // status
  output wire             SEQ_BUSY,
  output wire             SEQ_COMPLETE
);

  // sequencer states: idle waits for a control write, start issues
  // one conversion request, wait holds until the machine answers
  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_WAIT  = 2'h2;

  // control registers
  reg  [7:0]       len_fifo_q;
  reg  [7:0]       clk_res_q;
  reg  [7:0]       seq_ctrl_q;

  // sequencer state and its next values
  reg  [1:0]       state_q;
  reg  [1:0]       state_d;
  reg  [2:0]       ptr_q;
  reg  [2:0]       ptr_d;
  reg  [2:0]       pos_q;
  reg  [2:0]       pos_d;
  reg  [2:0]       chan_d;

  // completion flags
  reg              seq_flag_q;
  reg              seq_flag_d;
  reg  [7:0]       conv_flags_q;
  reg  [7:0]       conv_flags_d;

  // conversion clock prescaler
  reg  [4:0]       pre_cnt_q;
  reg              half_q;

  // result file and read path
  reg  [15:0]      result_q [0:7];
  reg  [7:0]       rdata_d;
  reg  [2:0]       seq_last;
  reg  [3:0]       res_idx;

  // register port decode
  wire             wr_len   = WR_STB && (ADDR == `OFS_LENGTH_FIFO);
  wire             wr_clk   = WR_STB && (ADDR == `OFS_CLOCK_RES);
  wire             wr_seq   = WR_STB && (ADDR == `OFS_SEQ_CTRL);
  wire             restart  = wr_clk || wr_seq;

  // decoded control fields
  wire             fifo_on  = len_fifo_q[`BIT_FIFO_MODE];
  wire             scan_on  = seq_ctrl_q[`BIT_SCAN];
  wire             multi_on = seq_ctrl_q[`BIT_MULTI];
  wire [2:0]       chan_cfg = seq_ctrl_q[`CHAN_MSB:0];

  // prescaler and sequencer conditions
  wire [4:0]       prescale_value      = {2'h0, clk_res_q[`PRS_USED_MSB:0]};
  wire             pre_wrap = (pre_cnt_q == prescale_value);
  wire             done_ok  = (state_q == ST_WAIT) && CONV_DONE && !restart;
  wire             last_one = (pos_q == seq_last);

  // sequence length, eight-conversion bit dominates
  always @* begin
    if (seq_ctrl_q[`BIT_EIGHT_CONV]) begin
      seq_last = `LEN_EIGHT;
    end else if (len_fifo_q[`BIT_SINGLE_CONV]) begin
      seq_last = `LEN_ONE;
    end else begin
      seq_last = `LEN_FOUR;
    end
  end

  // control registers; length and sequence bits that do not exist never store, the clock register stores all eight
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      len_fifo_q <= `RST_LENGTH_FIFO;
      clk_res_q  <= `RST_CLOCK_RES;
      seq_ctrl_q <= `RST_SEQ_CTRL;
    end else begin
      if (wr_len) begin
        len_fifo_q <= WDATA & `MSK_LENGTH_FIFO;
      end
      if (wr_clk) begin
        clk_res_q <= WDATA;
      end
      if (wr_seq) begin
        seq_ctrl_q <= WDATA & `MSK_SEQ_CTRL;
      end
    end
  end

  // prescaler: modulus counter of prs+1 then a divide by two;
  // only the three low code bits count, upper codes are not for use;
  // the code is not checked against the bus clock rate, software
  // keeps the conversion clock inside its legal band
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pre_cnt_q <= 5'h00;
      half_q    <= 1'b0;
    end else if (restart) begin
      pre_cnt_q <= 5'h00; // restart keeps the first period full
      half_q    <= 1'b0;
    end else if (pre_wrap) begin
      pre_cnt_q <= 5'h00;
      half_q    <= ~half_q;
    end else begin
      pre_cnt_q <= pre_cnt_q + 5'h01;
    end
  end

  // one tick per conversion clock period: 2*(code+1) REF_CLK cycles
  assign CONV_CLK_TICK = pre_wrap && half_q;

  // sequencer next state; a control write wins over a same-cycle done,
  // so a result of an abandoned sequence never sets a flag
  always @* begin
    state_d      = state_q;
    ptr_d        = ptr_q;
    pos_d        = pos_q;
    chan_d       = CONV_CHANNEL;
    seq_flag_d   = seq_flag_q;
    conv_flags_d = conv_flags_q;
    if (restart) begin
      state_d      = ST_START;
      pos_d        = 3'h0;
      seq_flag_d   = 1'b0;
      conv_flags_d = 8'h00;
      chan_d       = wr_seq ? WDATA[`CHAN_MSB:0] : chan_cfg;
      if (!fifo_on) begin
        ptr_d = 3'h0;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_START: begin
          state_d = ST_WAIT;
        end
        ST_WAIT: begin
          if (CONV_DONE) begin
            // flag index follows the pointer, so fifo flags track registers
            conv_flags_d[ptr_q] = 1'b1;
            ptr_d = ptr_q + 3'h1;
            pos_d = pos_q + 3'h1;
            if (multi_on) begin
              chan_d = CONV_CHANNEL + 3'h1;
            end
            state_d = ST_START;
            if (last_one) begin
              seq_flag_d = 1'b1;
              pos_d      = 3'h0;
              chan_d     = chan_cfg;
              if (!fifo_on) begin
                ptr_d = 3'h0;
              end
              if (!scan_on) begin
                state_d = ST_IDLE;
              end
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // sequencer registers
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q      <= ST_IDLE;
      ptr_q        <= 3'h0;
      pos_q        <= 3'h0;
      CONV_CHANNEL <= 3'h0;
      CONV_SPECIAL <= 1'b0;
      seq_flag_q   <= 1'b0;
      conv_flags_q <= 8'h00;
    end else begin
      state_q      <= state_d;
      ptr_q        <= ptr_d;
      pos_q        <= pos_d;
      CONV_CHANNEL <= chan_d;
      seq_flag_q   <= seq_flag_d;
      conv_flags_q <= conv_flags_d;
      if (wr_seq) begin
        CONV_SPECIAL <= WDATA[`BIT_SPECIAL];
      end
    end
  end

  // result file, one word per register; index is the pointer
  // the store is blocked in the cycle of a control write, so an
  // abandoned sequence never overwrites a result
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_res
      always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
          result_q[gi] <= 16'h0000;
        end else if (done_ok && (ptr_q == gi)) begin
          result_q[gi] <= {CONV_RESULT, {(16-RES_W){1'b0}}};
        end
      end
    end
  endgenerate

  // read mux; results left justified, high byte at even offset
  always @* begin
    res_idx = ADDR[3:0];
    rdata_d = 8'h00;
    if (ADDR == `OFS_LENGTH_FIFO) begin
      rdata_d = len_fifo_q;
    end else if (ADDR == `OFS_CLOCK_RES) begin
      rdata_d = clk_res_q;
    end else if (ADDR == `OFS_SEQ_CTRL) begin
      rdata_d = {1'b0, seq_ctrl_q[6:0]};
    end else if (ADDR == `OFS_STATUS_SEQ) begin
      // sequence flag on top, result pointer below
      rdata_d = {seq_flag_q, 4'h0, ptr_q};
    end else if (ADDR == `OFS_STATUS_CONV) begin
      rdata_d = conv_flags_q;
    end else if ((ADDR >= `OFS_RESULT_BASE) && (ADDR <= `OFS_RESULT_LAST)) begin
      rdata_d = res_idx[0] ? result_q[res_idx[3:1]][7:0]
                           : result_q[res_idx[3:1]][15:8];
    end
  end

  // read data stands only in the cycle after the strobe
  // zero elsewhere, so several slaves can share one or-ed read bus
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 8'h00;
    end else if (RD_STB) begin
      RDATA <= rdata_d;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // machine handshake; abort cuts off a conversion in flight
  // start is masked in the cycle of a control write: that request
  // would belong to the sequence that is being abandoned
  assign CONV_START   = (state_q == ST_START) && !restart;
  assign CONV_ABORT   = restart && (state_q != ST_IDLE);
  assign CONV_RES10   = clk_res_q[`BIT_RES10];
  assign SEQ_BUSY     = (state_q != ST_IDLE);
  assign SEQ_COMPLETE = seq_flag_q;

endmodule
`default_nettype wire

// *** verification/adc_seq_checker.sv ***
/* port checker of the sequencer.
   assumes one clock, bound to adc_sequence_control. */
`timescale 1ns/10ps
`default_nettype none
module adc_seq_checker (
  // watched ports
  input wire logic       REF_CLK,
  input wire logic       RST_B,
  input wire logic [7:0] ADDR,
  input wire logic       WR_STB,
  input wire logic       RD_STB,
  input wire logic [7:0] RDATA,
  input wire logic       CONV_CLK_TICK,
  input wire logic       CONV_START,
  input wire logic       CONV_ABORT,
  input wire logic       CONV_DONE,
  input wire logic       SEQ_BUSY,
  input wire logic       SEQ_COMPLETE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // either control register write restarts
  wire ctl_wr = WR_STB && (ADDR == 8'h64 || ADDR == 8'h65);
  property p_abort; CONV_ABORT == (ctl_wr && SEQ_BUSY); endproperty
  a_abort: assert property (p_abort) else $error("abort wrong");
  property p_restart; ctl_wr ##1 !ctl_wr |-> CONV_START; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_clear; ctl_wr |=> !SEQ_COMPLETE; endproperty
  a_clear: assert property (p_clear) else $error("flag kept");
  property p_bit7; RD_STB && ADDR == 8'h65 |=> !RDATA[7]; endproperty
  a_bit7: assert property (p_bit7) else $error("bit 7 set");
  property p_tick; CONV_CLK_TICK |=> !CONV_CLK_TICK; endproperty
  a_tick: assert property (p_tick) else $error("tick wide");
  property p_idle; !SEQ_BUSY && !ctl_wr |=> !CONV_START; endproperty
  a_idle: assert property (p_idle) else $error("idle start");
  property p_flag; $rose(SEQ_COMPLETE) |-> $past(CONV_DONE); endproperty
  a_flag: assert property (p_flag) else $error("flag w/o done");
  property p_pulse; CONV_START |=> !CONV_START; endproperty
  a_pulse: assert property (p_pulse) else $error("start wide");
  c_scan: cover property (SEQ_COMPLETE && CONV_START);
  c_abort: cover property (CONV_ABORT);
  c_done: cover property (CONV_DONE && SEQ_BUSY);
endmodule
bind adc_sequence_control adc_seq_checker chk_i (.REF_CLK(REF_CLK), .RST_B(RST_B),
  .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
  .CONV_CLK_TICK(CONV_CLK_TICK), .CONV_START(CONV_START), .CONV_ABORT(CONV_ABORT),
  .CONV_DONE(CONV_DONE), .SEQ_BUSY(SEQ_BUSY), .SEQ_COMPLETE(SEQ_COMPLETE));
`default_nettype wire

// *** verification/conv_machine_model.sv ***
/* conversion machine: one done per start after lat cycles.
   assumes start and abort are one-cycle pulses. */
`timescale 1ns/10ps
`default_nettype none
module conv_machine_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // request
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [2:0] chan,
  input  wire logic       special,
  input  wire logic [3:0] lat,
  // answer
  output logic            done,
  output logic [9:0]      result
);
  logic       busy_q;
  logic [3:0] cnt_q;
  // abort drops the job so no stale done reaches a new sequence
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
    end else if (abort) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
      cnt_q  <= lat;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - 4'h1;
      busy_q <= cnt_q != 4'h0;
    end
  end
  // result tells source and channel; inverted when not valid
  assign done   = busy_q && cnt_q == 4'h0;
  assign result = done ? {special, chan, 6'h15} : ~{special, chan, 6'h15};
endmodule
`default_nettype wire

// *** verification/adc_sequence_control_tb.sv ***
/* bench of the sequencer: register tasks and sequences.
   assumes design, checker and conversion model compiled before. */
`timescale 1ns/10ps
`default_nettype none
module adc_sequence_control_tb;
  logic       clk = 0, rst_b = 0, wr = 0, rd = 0;
  logic       done, tk, st, ab, sp, busy, cmpl, r10;
  logic [7:0] addr = 0, wdat = 0, rdat, c;
  logic [2:0] ch;
  logic [9:0] res;
  logic [3:0] lat = 4'h1;
  int         n_fail = 0, cmp_count = 0;
  always #5 clk = ~clk;
  adc_sequence_control uut (.REF_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdat),
    .WR_STB(wr), .RD_STB(rd), .RDATA(rdat), .CONV_CLK_TICK(tk), .CONV_START(st),
    .CONV_ABORT(ab), .CONV_CHANNEL(ch), .CONV_SPECIAL(sp), .CONV_RES10(r10),
    .CONV_DONE(done), .CONV_RESULT(res), .SEQ_BUSY(busy), .SEQ_COMPLETE(cmpl));
  conv_machine_model far (.clk(clk), .rst_b(rst_b), .start(st), .abort(ab),
    .chan(ch), .special(sp), .lat(lat), .done(done), .result(res));
  task chk(input logic [7:0] g, e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task rd_reg(input logic [7:0] a, e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, e);
  endtask
  task wait_seq;
    int n;
    n = 0;
    #1;
    while (cmpl !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    chk({7'h0, cmpl}, 8'h01);
  endtask
  task tick_gap(input logic [7:0] k);
    logic [7:0] g;
    g = 0;
    wr_reg(8'h64, k);
    #1;
    while (tk !== 1'b1 && g < 40) begin
      @(posedge clk);
      #1 g++;
    end
    g = 0;
    do begin
      @(posedge clk);
      #1 g++;
    end while (tk !== 1'b1 && g < 40);
    chk(g, 8'(2 * k + 2));
  endtask
  task finish_test;
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(8'h64, 8'h01);
    rd_reg(8'h50, 8'h00);
    // eight wins over single; channel code wraps past 7
    wr_reg(8'h63, 8'h08);
    wr_reg(8'h65, 8'hd4);
    wait_seq;
    rd_reg(8'h65, 8'h54);
    rd_reg(8'h67, 8'hff);
    rd_reg(8'h66, 8'h80);
    for (int i = 0; i < 8; i++)
      rd_reg(8'h70 + 8'(2 * i), {1'b0, 3'(4 + i), 4'h5});
    // every input channel, then the three reference sources, slow answers
    lat <= 4'h9;
    for (int i = 0; i < 11; i++) begin
      c = (i < 8) ? 8'(i) : 8'(i + 4);
      wr_reg(8'h65, c);
      wait_seq;
      rd_reg(8'h67, 8'h01);
      rd_reg(8'h70, {c[3:0], 4'h5});
    end
    wr_reg(8'h63, 8'h00);
    wr_reg(8'h65, 8'h03);
    wait_seq;
    rd_reg(8'h67, 8'h0f);
    rd_reg(8'h76, 8'h35);
    // fifo order runs on across sequences and wraps
    wr_reg(8'h63, 8'h04);
    wr_reg(8'h65, 8'h00);
    wait_seq;
    rd_reg(8'h66, 8'h84);
    wr_reg(8'h65, 8'h01);
    wait_seq;
    rd_reg(8'h66, 8'h80);
    rd_reg(8'h67, 8'hf0);
    rd_reg(8'h7e, 8'h15);
    rd_reg(8'h70, 8'h05);
    wr_reg(8'h63, 8'h08);
    wr_reg(8'h65, 8'h20);
    wait_seq;
    repeat (50) @(posedge clk);
    #1 chk({7'h0, busy}, 8'h01);
    wr_reg(8'h65, 8'h00);
    wait_seq;
    repeat (5) @(posedge clk);
    #1 chk({7'h0, busy}, 8'h00);
    for (int k = 0; k < 8; k++)
      tick_gap(8'(k));
    // resolution bit reaches the machine; the write also restarts
    wr_reg(8'h64, 8'h81);
    #1 chk({7'h0, r10}, 8'h01);
    chk({7'h0, busy}, 8'h01);
    finish_test;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    finish_test;
  end
endmodule
`default_nettype wire
